// ### shared/crc_defines.vh
// Purpose: constants for the cpu reset, low-power and indexed access control
// Assumes: byte-wide register port with a 9-bit address
// Notes: addresses below 0x100 are the direct page
`ifndef CRC_DEFINES_VH
`define CRC_DEFINES_VH

`define CRC_ADDR_W 9
`define CRC_PC_W 14
`define CRC_PCH_W 6
`define CRC_PCL_W 8

// direct page locations
`define CRC_ADDR_WINDOW 9'h00E
`define CRC_ADDR_POINTER 9'h00F
`define CRC_IDX_POINTER 8'h0F
`define CRC_PAGE_TOP 9'h0FF

// control space above the direct page
`define CRC_ADDR_PC_LOW 9'h100
`define CRC_ADDR_PC_HIGH 9'h101
`define CRC_ADDR_SPC_LOW 9'h102
`define CRC_ADDR_SPC_HIGH 9'h103
`define CRC_ADDR_FLAGS 9'h104
`define CRC_ADDR_STATUS 9'h105
`define CRC_ADDR_COMMAND 9'h106
`define CRC_ADDR_SHIFT 9'h107

// flag register fields
`define CRC_FLAG_C 0
`define CRC_FLAG_Z 1

// status register fields
`define CRC_ST_STATE_LSB 0
`define CRC_ST_WAKE 3
`define CRC_ST_CAUSE_EXT 4
`define CRC_ST_CAUSE_INT 5
`define CRC_ST_DBG 6

// command codes
`define CRC_CMD_STEP 8'h01
`define CRC_CMD_WAIT 8'h02
`define CRC_CMD_STOP 8'h03
`define CRC_CMD_LSL 8'h04
`define CRC_CMD_ASL 8'h05

// core states
`define CRC_S_RUN 3'h0
`define CRC_S_EXEC 3'h1
`define CRC_S_WAIT 3'h2
`define CRC_S_STOP 3'h3
`define CRC_S_BGND 3'h4
`define CRC_S_RCLS 3'h5
`define CRC_S_RHOLD 3'h6

`define CRC_RESET_VECTOR 14'h3FFD
`define CRC_INSTR_CYCLES 3

`endif

// ### src/crc_cpu_ctrl.v
// Purpose: reset sequence, low-power entry, background entry and indexed
//          access control of a small 8-bit core
// Assumes: all inputs synchronous to clk_in; reset events arrive as levels
// Notes: direct page is held here in flip-flops
//
// Contract
// [RULE_01] indexed address taken from live pointer byte
// [RULE_02] window access reaches page location at pointer
// [RULE_03] window usable as any short/direct operand
// [RULE_04] reset aborts running instruction at once
// [RULE_05] reset start classifies and records its cause
// [RULE_06] clocks stay stopped while reset source asserted
// [RULE_07] on release restart clocks, pc 3FFD, fetch
// [RULE_08] low debug pin at release enters background
// [RULE_09] debug request replaces next instruction with background
// [RULE_10] interrupts only wake, polled in run
// [RULE_11] wait/stop gate core clocks, suspend activity
// [RULE_12] low-power held until interrupt or reset
// [RULE_13] background halts user code, awaits host commands
// [RULE_14] arithmetic shift left equals logical shift left
// [RULE_15] pc is six-bit high, eight-bit low
// [RULE_16] shadow pc split six-bit high, eight-bit low
// [RULE_17] flags hold zero and carry, per-instruction effects
// [RULE_18] pointer zero-extended into 14-bit address
`include "crc_defines.vh"

module crc_cpu_ctrl #(
	parameter INSTR_CYCLES = `CRC_INSTR_CYCLES,
	parameter PAGE_DEPTH = 256
) (
	// clock and reset
	input wire clk_in,
	input wire reset_in,
	input wire clk_en_in,
	// register port
	input wire [`CRC_ADDR_W-1:0] addr_in,
	input wire [7:0] wr_data_in,
	input wire wr_in,
	input wire rd_in,
	output reg [7:0] rd_data_out,
	// reset sources
	input wire rst_ext_in,
	input wire rst_int_in,
	// wake and debug
	input wire wake_in,
	input wire debug_entry_pin_in,
	input wire dbg_req_in,
	input wire dbg_go_in,
	// core status
	output reg core_clk_en_out,
	output reg fetch_out,
	output reg bgnd_out,
	output reg [2:0] state_out,
	output reg [`CRC_PC_W-1:0] indexed_addr_out
);

	reg [7:0] page_reg [0:PAGE_DEPTH-1];
	reg [2:0] state_reg;
	reg [`CRC_PCH_W-1:0] pc_high_reg;
	reg [`CRC_PCL_W-1:0] pc_low_reg;
	reg [`CRC_PCH_W-1:0] shadow_pc_high_reg;
	reg [`CRC_PCL_W-1:0] shadow_pc_low_reg;
	reg [1:0] flag_register_reg;
	reg [1:0] cause_reg;
	reg wake_flag_reg;
	reg dbg_pend_reg;
	reg [7:0] cycle_reg;
	reg [7:0] shift_reg;
	reg [7:0] rd_next;
	integer i;

	wire rst_src = rst_ext_in | rst_int_in;
	wire in_reset = (state_reg == `CRC_S_RCLS) || (state_reg == `CRC_S_RHOLD);
	wire [7:0] pointer = page_reg[`CRC_IDX_POINTER];
	wire [`CRC_PC_W-1:0] pc_full = {pc_high_reg, pc_low_reg};
	wire [`CRC_PC_W-1:0] pc_inc = pc_full + 14'h0001;
	wire bus_wr = wr_in & ~in_reset;
	wire bus_rd = rd_in & ~in_reset;
	wire cmd_wr = bus_wr && (addr_in == `CRC_ADDR_COMMAND);

	// map a bus address onto a direct page index, window goes through pointer
	function [7:0] page_index;
		input [`CRC_ADDR_W-1:0] a;
		input [7:0] ptr;
		begin
			if (a == `CRC_ADDR_WINDOW) begin
				page_index = ptr; // RULE_02
			end else begin
				page_index = a[7:0];
			end
		end
	endfunction

	// one shared left shift: asl and lsl decode to this alone
	function [9:0] shift_left;
		input [7:0] v;
		reg [7:0] r;
		begin
			r = {v[6:0], 1'b0};
			shift_left = {(r == 8'h00), v[7], r};
		end
	endfunction

	wire [7:0] bus_idx = page_index(addr_in, pointer); // RULE_03
	wire [9:0] shift_res = shift_left(shift_reg);

	// read mux; window read returns the byte the pointer names now
	always @* begin
		rd_next = 8'h00;
		if (addr_in <= `CRC_PAGE_TOP) begin
			rd_next = page_reg[bus_idx]; // RULE_01
		end else begin
			case (addr_in)
				`CRC_ADDR_PC_LOW: rd_next = pc_low_reg;
				`CRC_ADDR_PC_HIGH: rd_next = {2'b00, pc_high_reg};
				`CRC_ADDR_SPC_LOW: rd_next = shadow_pc_low_reg;
				`CRC_ADDR_SPC_HIGH: rd_next = {2'b00, shadow_pc_high_reg};
				`CRC_ADDR_FLAGS: rd_next = {6'h00, flag_register_reg};
				`CRC_ADDR_STATUS: rd_next = {1'b0, dbg_pend_reg, cause_reg,
					wake_flag_reg, state_reg};
				`CRC_ADDR_SHIFT: rd_next = shift_reg;
				default: rd_next = 8'h00;
			endcase
		end
	end

	// register port and direct page storage
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rd_data_out <= 8'h00;
			for (i = 0; i < PAGE_DEPTH; i = i + 1) begin
				page_reg[i] <= 8'h00;
			end
		end else if (clk_en_in) begin
			rd_data_out <= bus_rd ? rd_next : 8'h00;
			if (bus_wr && (addr_in <= `CRC_PAGE_TOP)) begin
				page_reg[bus_idx] <= wr_data_in; // RULE_02
			end
		end
	end

	// pointer always read live, zero-extended into the direct page
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			indexed_addr_out <= 14'h0000;
		end else if (clk_en_in) begin
			indexed_addr_out <= {6'h00, pointer}; // RULE_18 RULE_01
		end
	end

	// polled wake flag and pending debug request; set beats clear
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			wake_flag_reg <= 1'b0;
			dbg_pend_reg <= 1'b0;
		end else if (clk_en_in) begin
			if (wake_in) begin
				wake_flag_reg <= 1'b1; // RULE_10
			end else if (bus_wr && (addr_in == `CRC_ADDR_STATUS) &&
				wr_data_in[`CRC_ST_WAKE]) begin
				wake_flag_reg <= 1'b0;
			end
			if (dbg_req_in) begin
				dbg_pend_reg <= 1'b1;
			end else if (state_reg == `CRC_S_BGND || in_reset) begin
				dbg_pend_reg <= 1'b0;
			end
		end
	end

	// flag register and shift operand
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			flag_register_reg <= 2'b00;
			shift_reg <= 8'h00;
		end else if (clk_en_in && !in_reset) begin
			if (cmd_wr && state_reg == `CRC_S_RUN &&
				(wr_data_in == `CRC_CMD_LSL || wr_data_in == `CRC_CMD_ASL)) begin
				shift_reg <= shift_res[7:0]; // RULE_14
				flag_register_reg[`CRC_FLAG_C] <= shift_res[8]; // RULE_17
				flag_register_reg[`CRC_FLAG_Z] <= shift_res[9]; // RULE_17
			end else begin
				if (bus_wr && addr_in == `CRC_ADDR_FLAGS) begin
					flag_register_reg <= wr_data_in[1:0]; // RULE_17
				end
				if (bus_wr && addr_in == `CRC_ADDR_SHIFT) begin
					shift_reg <= wr_data_in;
				end
			end
		end
	end

	// core sequencer
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_reg <= `CRC_S_RHOLD;
			pc_high_reg <= 6'h00;
			pc_low_reg <= 8'h00;
			shadow_pc_high_reg <= 6'h00;
			shadow_pc_low_reg <= 8'h00;
			cause_reg <= 2'b00;
			cycle_reg <= 8'h00;
			core_clk_en_out <= 1'b0;
			fetch_out <= 1'b0;
			bgnd_out <= 1'b0;
			state_out <= `CRC_S_RHOLD;
		end else if (clk_en_in) begin
			fetch_out <= 1'b0;
			if (rst_src && !in_reset) begin
				// instruction dropped mid-way, no remaining cycles run
				state_reg <= `CRC_S_RCLS; // RULE_04
				cycle_reg <= 8'h00;
				cause_reg <= {rst_int_in, rst_ext_in}; // RULE_05
				core_clk_en_out <= 1'b0;
				bgnd_out <= 1'b0;
				state_out <= `CRC_S_RCLS;
			end else begin
				case (state_reg)
					`CRC_S_RCLS: begin
						state_reg <= `CRC_S_RHOLD;
						state_out <= `CRC_S_RHOLD;
						core_clk_en_out <= 1'b0; // RULE_06
					end
					`CRC_S_RHOLD: begin
						if (!rst_src) begin
							{pc_high_reg, pc_low_reg} <= `CRC_RESET_VECTOR; // RULE_07
							core_clk_en_out <= 1'b1; // RULE_07
							if (!debug_entry_pin_in) begin
								state_reg <= `CRC_S_BGND; // RULE_08
								state_out <= `CRC_S_BGND;
								bgnd_out <= 1'b1;
								{shadow_pc_high_reg, shadow_pc_low_reg} <=
									`CRC_RESET_VECTOR;
							end else begin
								state_reg <= `CRC_S_RUN;
								state_out <= `CRC_S_RUN;
								fetch_out <= 1'b1; // RULE_07
							end
						end else begin
							core_clk_en_out <= 1'b0; // RULE_06
						end
					end
					`CRC_S_RUN: begin
						if (dbg_pend_reg) begin
							// taken in place of the next instruction
							state_reg <= `CRC_S_BGND; // RULE_09
							state_out <= `CRC_S_BGND;
							bgnd_out <= 1'b1;
							{shadow_pc_high_reg, shadow_pc_low_reg} <= pc_full; // RULE_16
						end else if (cmd_wr && wr_data_in == `CRC_CMD_STEP) begin
							state_reg <= `CRC_S_EXEC;
							state_out <= `CRC_S_EXEC;
							cycle_reg <= 8'h01;
						end else if (cmd_wr && (wr_data_in == `CRC_CMD_WAIT ||
							wr_data_in == `CRC_CMD_STOP)) begin
							state_reg <= (wr_data_in == `CRC_CMD_WAIT) ?
								`CRC_S_WAIT : `CRC_S_STOP; // RULE_11
							state_out <= (wr_data_in == `CRC_CMD_WAIT) ?
								`CRC_S_WAIT : `CRC_S_STOP;
							core_clk_en_out <= 1'b0; // RULE_11
							{pc_high_reg, pc_low_reg} <= pc_inc; // RULE_15
							{shadow_pc_high_reg, shadow_pc_low_reg} <= pc_inc; // RULE_16
						end
					end
					`CRC_S_EXEC: begin
						if (cycle_reg >= INSTR_CYCLES[7:0]) begin
							cycle_reg <= 8'h00;
							{pc_high_reg, pc_low_reg} <= pc_inc; // RULE_15
							state_reg <= `CRC_S_RUN;
							state_out <= `CRC_S_RUN;
							fetch_out <= ~dbg_pend_reg;
						end else begin
							cycle_reg <= cycle_reg + 8'h01;
						end
					end
					`CRC_S_WAIT, `CRC_S_STOP: begin
						// only a wake event or reset ends low power
						if (wake_in) begin
							state_reg <= `CRC_S_RUN; // RULE_12 RULE_10
							state_out <= `CRC_S_RUN;
							core_clk_en_out <= 1'b1;
							fetch_out <= 1'b1;
						end
					end
					`CRC_S_BGND: begin
						// user code halted; host steers pc then resumes
						if (dbg_go_in) begin
							state_reg <= `CRC_S_RUN; // RULE_13
							state_out <= `CRC_S_RUN;
							bgnd_out <= 1'b0;
							fetch_out <= 1'b1;
						end else if (bus_wr && addr_in == `CRC_ADDR_PC_LOW) begin
							pc_low_reg <= wr_data_in; // RULE_15
						end else if (bus_wr && addr_in == `CRC_ADDR_PC_HIGH) begin
							pc_high_reg <= wr_data_in[5:0]; // RULE_15
						end
					end
					default: begin
						state_reg <= `CRC_S_RHOLD;
						state_out <= `CRC_S_RHOLD;
						core_clk_en_out <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule

// ### sim/crc_sva.sv
// Purpose: port checks of reset, low-power and indexed control
// Assumes: clk_en_in qualifies every taken request
// Notes: bound from tb_top
`include "crc_defines.vh"
module crc_sva (
	// clock and reset
	input wire clk_in,
	input wire reset_in,
	input wire clk_en_in,
	// register port
	input wire [`CRC_ADDR_W-1:0] addr_in,
	input wire [7:0] wr_data_in,
	input wire wr_in,
	// sources and status
	input wire rst_ext_in,
	input wire rst_int_in,
	input wire wake_in,
	input wire debug_entry_pin_in,
	input wire core_clk_en_out,
	input wire fetch_out,
	input wire bgnd_out,
	input wire [2:0] state_out,
	input wire [`CRC_PC_W-1:0] indexed_addr_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	wire src = rst_ext_in | rst_int_in;
	wire in_rst = state_out == `CRC_S_RCLS || state_out == `CRC_S_RHOLD;
	wire low = state_out == `CRC_S_WAIT || state_out == `CRC_S_STOP;
	a_idx_follow: assert property (clk_en_in && wr_in && addr_in == `CRC_ADDR_POINTER && !in_rst
		|=> ##1 indexed_addr_out == {6'h00, $past(wr_data_in, 2)}) else $error("pointer not followed");
	a_reset_abort: assert property (clk_en_in && src && !in_rst
		|=> state_out == `CRC_S_RCLS && !core_clk_en_out && !fetch_out) else $error("no abort");
	a_classify_hold: assert property (clk_en_in && state_out == `CRC_S_RCLS
		|=> state_out == `CRC_S_RHOLD) else $error("classify not followed by hold");
	a_hold_gated: assert property (in_rst |-> !core_clk_en_out) else $error("clock in reset");
	a_release_start: assert property ($past(state_out) == `CRC_S_RHOLD && !in_rst
		|-> state_out == ($past(debug_entry_pin_in) ? `CRC_S_RUN : `CRC_S_BGND)
		&& fetch_out == $past(debug_entry_pin_in) && core_clk_en_out) else $error("bad release");
	a_low_stay: assert property (clk_en_in && low && !wake_in && !src
		|=> $stable(state_out) && !core_clk_en_out) else $error("left low power");
	a_wake_run: assert property (clk_en_in && low && wake_in && !src
		|=> state_out == `CRC_S_RUN && fetch_out && core_clk_en_out) else $error("no wake");
	a_bgnd_halt: assert property (state_out == `CRC_S_BGND |-> bgnd_out && !fetch_out)
		else $error("background not halted");
	c_wake: cover property (low && wake_in);
	c_bgnd: cover property (state_out == `CRC_S_BGND);
	c_abort: cover property (state_out == `CRC_S_EXEC && src);
endmodule

// ### sim/crc_dbg_host.sv
// Purpose: behavioural debug host
// Assumes: tasks are called just after a clock edge
// Notes: pin rests high so a reset ends in run
module crc_dbg_host (
	// clock
	input wire clk_in,
	// debug lines
	output logic pin_out,
	output logic req_out,
	output logic go_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		pin_out = 1'b1;
		req_out = 1'b0;
		go_out = 1'b0;
	end
	task automatic set_pin(input logic v);
		pin_out <= v;
	endtask
	task automatic request();
		@(posedge clk_in);
		req_out <= 1'b1;
		@(posedge clk_in);
		req_out <= 1'b0;
	endtask
	// the host's resume command ends background
	task automatic resume();
		@(posedge clk_in);
		go_out <= 1'b1;
		@(posedge clk_in);
		go_out <= 1'b0;
	endtask
endmodule

// ### sim/tb_top.sv
// Purpose: directed bench for the cpu control block
// Assumes: crc_dbg_host plays the debug host
// Notes: clk_en_in held high except low for one pointer write
`include "crc_defines.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
	$display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in, reset_in, clk_en_in, wr_in, rd_in, rst_ext_in, rst_int_in, wake_in;
	logic pin, dreq, dgo, cke, fetch_out, bgnd_out;
	logic [8:0] addr_in;
	logic [7:0] wr_data_in, rd_data_out, rdv, pc_low;
	logic [7:0] ptrs [3] = '{8'h00, 8'h40, 8'hFF};
	logic [2:0] state_out;
	logic [13:0] idx;
	int err_count = 0, n_tests = 0, cyc = 0;
	crc_cpu_ctrl crc_cpu_ctrl_inst (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
		.addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
		.rd_data_out(rd_data_out), .rst_ext_in(rst_ext_in), .rst_int_in(rst_int_in),
		.wake_in(wake_in), .debug_entry_pin_in(pin), .dbg_req_in(dreq), .dbg_go_in(dgo),
		.core_clk_en_out(cke), .fetch_out(fetch_out), .bgnd_out(bgnd_out),
		.state_out(state_out), .indexed_addr_out(idx));
	crc_dbg_host crc_dbg_host_inst (.clk_in(clk_in), .pin_out(pin), .req_out(dreq), .go_out(dgo));
	task automatic tally_and_finish();
		if (err_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [8:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 rdv = rd_data_out;
	endtask
	task automatic reset_run();
		reset_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		#1;
	endtask
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			tally_and_finish();
		end
	end
	initial begin
		{reset_in, clk_en_in, wr_in, rd_in, rst_ext_in, rst_int_in, wake_in} = 7'b1100000;
		addr_in = 9'h000;
		wr_data_in = 8'h00;
		reset_run();
		`CHK({state_out, cke, fetch_out}, {`CRC_S_RUN, 2'b11})
		rd(`CRC_ADDR_PC_HIGH);
		`CHK(rdv, 8'h3F)
		rd(`CRC_ADDR_PC_LOW);
		`CHK(rdv, 8'hFD)
		foreach (ptrs[i]) begin
			wr(`CRC_ADDR_POINTER, ptrs[i]);
			// indexed address is registered one cycle behind the pointer byte
			@(posedge clk_in);
			#1 `CHK(idx, {6'h00, ptrs[i]})
			wr(`CRC_ADDR_WINDOW, ~ptrs[i]);
			rd({1'b0, ptrs[i]});
			`CHK(rdv, ~ptrs[i])
			rd(`CRC_ADDR_WINDOW);
			`CHK(rdv, ~ptrs[i])
		end
		// a write with the clock enable low must leave the pointer alone
		clk_en_in <= 1'b0;
		wr(`CRC_ADDR_POINTER, 8'h33);
		clk_en_in <= 1'b1;
		@(posedge clk_in);
		#1 `CHK(idx, 14'h00FF)
		wr(9'h108, 8'h5A);
		rd(9'h108);
		`CHK(rdv, 8'h00)
		for (int c = 0; c < 4; c++) begin
			wr(`CRC_ADDR_SHIFT, c[1] ? 8'h80 : 8'hC1);
			wr(`CRC_ADDR_COMMAND, c[0] ? `CRC_CMD_ASL : `CRC_CMD_LSL);
			rd(`CRC_ADDR_SHIFT);
			`CHK(rdv, c[1] ? 8'h00 : 8'h82)
			rd(`CRC_ADDR_FLAGS);
			`CHK(rdv[1:0], c[1] ? 2'b11 : 2'b01)
		end
		rd(`CRC_ADDR_PC_LOW);
		pc_low = rdv + 8'h01;
		wr(`CRC_ADDR_COMMAND, `CRC_CMD_STEP);
		#1 `CHK(state_out, `CRC_S_EXEC)
		repeat (`CRC_INSTR_CYCLES) @(posedge clk_in);
		#1 `CHK({state_out, fetch_out}, {`CRC_S_RUN, 1'b1})
		rd(`CRC_ADDR_PC_LOW);
		`CHK(rdv, pc_low)
		for (int m = 0; m < 2; m++) begin
			wr(`CRC_ADDR_COMMAND, m ? `CRC_CMD_STOP : `CRC_CMD_WAIT);
			repeat (4) @(posedge clk_in);
			#1 `CHK({state_out, cke}, {m ? `CRC_S_STOP : `CRC_S_WAIT, 1'b0})
			wake_in <= 1'b1;
			@(posedge clk_in);
			wake_in <= 1'b0;
			#1 `CHK({state_out, cke, fetch_out}, {`CRC_S_RUN, 2'b11})
			rd(`CRC_ADDR_STATUS);
			`CHK(rdv[3], 1'b1)
			wr(`CRC_ADDR_STATUS, 8'h08);
		end
		crc_dbg_host_inst.request();
		for (int i = 0; i < 8 && bgnd_out !== 1'b1; i++) @(posedge clk_in);
		#1 `CHK(state_out, `CRC_S_BGND)
		rd(`CRC_ADDR_PC_LOW);
		pc_low = rdv;
		rd(`CRC_ADDR_SPC_LOW);
		`CHK(rdv, pc_low)
		wr(`CRC_ADDR_COMMAND, `CRC_CMD_STEP);
		#1 `CHK(state_out, `CRC_S_BGND)
		crc_dbg_host_inst.resume();
		#1 `CHK({state_out, fetch_out}, {`CRC_S_RUN, 1'b1})
		for (int s = 0; s < 2; s++) begin
			wr(`CRC_ADDR_COMMAND, `CRC_CMD_STEP);
			{rst_int_in, rst_ext_in} <= s ? 2'b10 : 2'b01;
			@(posedge clk_in);
			#1 `CHK({state_out, cke}, {`CRC_S_RCLS, 1'b0})
			repeat (4) @(posedge clk_in);
			#1 `CHK({state_out, cke}, {`CRC_S_RHOLD, 1'b0})
			{rst_int_in, rst_ext_in} <= 2'b00;
			@(posedge clk_in);
			#1 `CHK({state_out, fetch_out}, {`CRC_S_RUN, 1'b1})
			rd(`CRC_ADDR_STATUS);
			`CHK(rdv[5:4], s ? 2'b10 : 2'b01)
		end
		crc_dbg_host_inst.set_pin(1'b0);
		reset_run();
		`CHK({state_out, bgnd_out, fetch_out}, {`CRC_S_BGND, 2'b10})
		crc_dbg_host_inst.set_pin(1'b1);
		tally_and_finish();
	end
endmodule
bind crc_cpu_ctrl crc_sva crc_sva_inst (.*);
